/* core/pcs_pkg.sv */
// constants for the port control and status register bank
package pcs_pkg;
  // register indices (byte address = index * 4)
  localparam logic [1:0] REG_CTRL_IDX = 2'h0;
  localparam logic [1:0] REG_STAT_IDX = 2'h1;
  localparam logic [1:0] REG_IDHI_IDX = 2'h2;
  localparam logic [3:0] REG_IRQ_STAT = 4'hC;
  localparam logic [3:0] REG_IRQ_MASK = 4'hD;
  // control word fields
  localparam int CTRL_RESET_BIT = 15;
  localparam int CTRL_SPEED_BIT = 13;
  localparam int CTRL_ANEN_BIT = 12;
  localparam int CTRL_PWDN_BIT = 11;
  localparam int CTRL_RSTAN_BIT = 9;
  localparam int CTRL_DUPLEX_BIT = 8;
  // status word fixed bits: caps 14..11, preamble 6, aneg able 3, ext regs 0
  localparam logic [15:0] STAT_FIXED = 16'h7849;
  localparam int STAT_DONE_BIT = 5;
  localparam int STAT_RFAULT_BIT = 4;
  localparam int STAT_LINK_BIT = 2;
  localparam int STAT_JABBER_BIT = 1;
  // identifier: value arbitrary, not a real maker code
  localparam logic [15:0] ID_HIGH_VALUE = 16'h1234;
  // soft reset length in cycles
  localparam int SOFT_RST_CYCLES = 4;
  localparam logic [2:0] SOFT_RST_LAST = 3'(SOFT_RST_CYCLES - 1);
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RFAULT = 1;
  localparam int IRQ_LINKDN = 2;
  localparam int IRQ_JABBER = 3;
  localparam int IRQ_W = 4;
endpackage

/* core/pcs_regs.sv */
// port control/status register bank behind a classic wishbone slave
`timescale 1ns/1ps
// What this block does
// - power down selects low power; leaving it forces soft reset and renegotiation
// - isolate bit reads zero, writes ignored
// - restart bit starts negotiation, self clears; any reset also restarts
// - collision test bit reads zero, no test function
// - upper speed bit and control bits 5..0 read zero
// - status bits 14..11 read one
// - status bits 15, 10, 9, 8, 7 read zero
// - status bit 6 reads one; preamble-less frames accepted
// - status bit 5 shows negotiation complete, resets to zero
// - status bit 4 latches high on far end fault
// - status bit 3 reads one, negotiation capable
// - link bit latches low on drop until read; read twice for live state
// - status bit 1 latches high on jabber
// - status bit 0 reads one, extended registers present
// - identifier word read-only, fixed across all resets
// - control bit 15 resets port at once, self clears when done
// - control bit 13 selects speed; change drops link, renegotiates
module pcs_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins: strap [2]=speed [1]=aneg enable [0]=duplex
  input wire logic [2:0] negotiation_strap_pins_i,
  input wire logic far_end_fault_i,
  input wire logic jabber_i,
  input wire logic link_up_i,
  // negotiation engine
  input wire logic negotiation_complete_i,
  output logic renegotiate_trigger_o,
  output logic port_reset_o,
  output logic low_power_select_o,
  output logic speed_fast_o,
  output logic negotiation_enable_o,
  output logic full_duplex_o,
  output logic link_drop_o,
  // interrupt
  output logic irq_o
);
  // pin synchronisers: two flops per pin, only the second one is read
  localparam int N_SYNC = 7;
  logic [N_SYNC-1:0] pins_raw;
  logic [N_SYNC-1:0] pins_s;
  logic [2:0] strap_s;
  logic fault_s;
  logic jabber_s;
  logic link_s;
  logic done_s;
  assign pins_raw = {negotiation_strap_pins_i, far_end_fault_i, jabber_i,
                     link_up_i, negotiation_complete_i};
  for (genvar g = 0; g < N_SYNC; g++) begin : g_sync
    logic meta_ff;
    logic safe_ff;
    always_ff @(posedge clk_i) begin
      meta_ff <= pins_raw[g];
      safe_ff <= meta_ff;
    end
    assign pins_s[g] = safe_ff;
  end
  // bits are independent levels, so no word needs a gray code here
  assign strap_s = pins_s[6:4];
  assign fault_s = pins_s[3];
  assign jabber_s = pins_s[2];
  assign link_s = pins_s[1];
  assign done_s = pins_s[0];

  // straps caught a few cycles after release so the synchroniser has settled
  logic [1:0] strap_wait_ff;
  logic strap_load;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_wait_ff <= 2'h0;
    end else if (strap_wait_ff != 2'h3) begin
      strap_wait_ff <= strap_wait_ff + 2'h1;
    end
  end
  assign strap_load = (strap_wait_ff == 2'h2);

  // one-hot register select, shared by the write strobes and the read side
  localparam int SEL_CTRL = 0;
  localparam int SEL_STAT = 1;
  localparam int SEL_IDHI = 2;
  localparam int SEL_ISTAT = 3;
  localparam int SEL_IMASK = 4;
  function automatic logic [4:0] reg_select(input logic [3:0] index);
    logic [4:0] hit;
    hit = 5'h00;
    case (index)
      {2'h0, pcs_pkg::REG_CTRL_IDX}: hit[SEL_CTRL] = 1'b1;
      {2'h0, pcs_pkg::REG_STAT_IDX}: hit[SEL_STAT] = 1'b1;
      {2'h0, pcs_pkg::REG_IDHI_IDX}: hit[SEL_IDHI] = 1'b1;
      pcs_pkg::REG_IRQ_STAT: hit[SEL_ISTAT] = 1'b1;
      pcs_pkg::REG_IRQ_MASK: hit[SEL_IMASK] = 1'b1;
      default: hit = 5'h00;
    endcase
    return hit;
  endfunction

  // wishbone decode
  logic req;
  logic [3:0] idx;
  logic [4:0] rsel;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_stat;
  logic rd_irq;
  logic [15:0] wdat;
  // ack gates req so a held strobe is taken only once
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx = wb_adr_i[5:2];
  assign rsel = reg_select(idx);
  assign wdat = wb_dat_i[15:0];
  assign wr_ctrl = req && wb_we_i && rsel[SEL_CTRL] && wb_sel_i[1];
  assign wr_mask = req && wb_we_i && rsel[SEL_IMASK] && wb_sel_i[0];
  assign rd_stat = req && !wb_we_i && rsel[SEL_STAT];
  assign rd_irq = req && !wb_we_i && rsel[SEL_ISTAT];

  // soft reset sequencing
  logic pwdn_ff;
  logic [2:0] srst_cnt_ff;
  logic srst_busy;
  logic wake;
  logic srst_req;
  assign srst_busy = (srst_cnt_ff != 3'h0);
  assign wake = wr_ctrl && wb_sel_i[1] && pwdn_ff && !wdat[pcs_pkg::CTRL_PWDN_BIT];
  assign srst_req = (wr_ctrl && wdat[pcs_pkg::CTRL_RESET_BIT]) || wake;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srst_cnt_ff <= 3'h0;
    end else if (srst_req) begin
      srst_cnt_ff <= pcs_pkg::SOFT_RST_LAST + 3'h1;
    end else if (srst_busy) begin
      srst_cnt_ff <= srst_cnt_ff - 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_reset_o <= 1'b0;
    end else begin
      port_reset_o <= srst_req || (srst_cnt_ff > 3'h1);
    end
  end

  // pending mode bits written by software, applied only at soft reset or wake
  logic [2:0] pend_ff;
  logic [2:0] mode_ff;
  logic [2:0] pend_new;
  assign pend_new = {wdat[pcs_pkg::CTRL_SPEED_BIT], wdat[pcs_pkg::CTRL_ANEN_BIT],
                     wdat[pcs_pkg::CTRL_DUPLEX_BIT]};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff <= 3'h0;
      mode_ff <= 3'h0;
    end else if (strap_load) begin
      pend_ff <= strap_s;
      mode_ff <= strap_s;
    end else if (srst_req) begin
      pend_ff <= wr_ctrl && wb_sel_i[1] ? pend_new : pend_ff;
      mode_ff <= wr_ctrl && wb_sel_i[1] ? pend_new : pend_ff;
    end else if (wr_ctrl) begin
      pend_ff <= pend_new;
    end
  end
  assign speed_fast_o = mode_ff[2];
  assign negotiation_enable_o = mode_ff[1];
  assign full_duplex_o = mode_ff[0];

  logic speed_q_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_q_ff <= 1'b0;
      link_drop_o <= 1'b0;
    end else if (strap_load) begin
      // straps set the first speed, which is no change: track it silently
      speed_q_ff <= strap_s[2];
      link_drop_o <= 1'b0;
    end else begin
      speed_q_ff <= mode_ff[2];
      link_drop_o <= (speed_q_ff != mode_ff[2]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwdn_ff <= 1'b0;
    end else if (wr_ctrl) begin
      pwdn_ff <= wdat[pcs_pkg::CTRL_PWDN_BIT];
    end
  end
  assign low_power_select_o = pwdn_ff;

  // negotiation restart pulse
  logic restart_hw;
  assign restart_hw = strap_load;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      renegotiate_trigger_o <= 1'b0;
    end else begin
      renegotiate_trigger_o <= (wr_ctrl && wdat[pcs_pkg::CTRL_RSTAN_BIT])
        || restart_hw || srst_req
        || (link_drop_o && mode_ff[1]);
    end
  end

  // latched status flags; the done flag is registered as is, not latched
  logic rfault_ff;
  logic jabber_ff;
  logic link_ff;
  logic done_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || port_reset_o) begin
      rfault_ff <= 1'b0;
      jabber_ff <= 1'b0;
      link_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= done_s;
      // set wins over the clear done by a read
      rfault_ff <= fault_s || (rfault_ff && !rd_stat);
      jabber_ff <= jabber_s || (jabber_ff && !rd_stat);
      link_ff <= link_s && (link_ff || rd_stat);
    end
  end

  // control and status words as read
  logic [15:0] ctrl_rd;
  logic [15:0] stat_rd;
  always_comb begin
    ctrl_rd = 16'h0000;
    ctrl_rd[pcs_pkg::CTRL_RESET_BIT] = srst_busy;
    ctrl_rd[pcs_pkg::CTRL_SPEED_BIT] = pend_ff[2];
    ctrl_rd[pcs_pkg::CTRL_ANEN_BIT] = pend_ff[1];
    ctrl_rd[pcs_pkg::CTRL_PWDN_BIT] = pwdn_ff;
    ctrl_rd[pcs_pkg::CTRL_DUPLEX_BIT] = pend_ff[0];
  end
  always_comb begin
    stat_rd = pcs_pkg::STAT_FIXED;
    stat_rd[pcs_pkg::STAT_DONE_BIT] = done_ff;
    stat_rd[pcs_pkg::STAT_RFAULT_BIT] = rfault_ff;
    stat_rd[pcs_pkg::STAT_LINK_BIT] = link_ff;
    stat_rd[pcs_pkg::STAT_JABBER_BIT] = jabber_ff;
  end

  // interrupts: sticky status cleared by reading it, mask of same layout
  logic [pcs_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [pcs_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [pcs_pkg::IRQ_W-1:0] irq_ev;
  logic done_q_ff;
  logic link_q_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q_ff <= 1'b0;
      link_q_ff <= 1'b0;
    end else begin
      done_q_ff <= done_s;
      link_q_ff <= link_s;
    end
  end
  always_comb begin
    irq_ev = '0;
    irq_ev[pcs_pkg::IRQ_DONE] = done_s && !done_q_ff;
    irq_ev[pcs_pkg::IRQ_RFAULT] = fault_s;
    irq_ev[pcs_pkg::IRQ_LINKDN] = link_q_ff && !link_s;
    irq_ev[pcs_pkg::IRQ_JABBER] = jabber_s;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= irq_ev | (rd_irq ? '0 : irq_stat_ff);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_ff <= '0;
    end else if (wr_mask) begin
      irq_mask_ff <= wb_dat_i[pcs_pkg::IRQ_W-1:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // bus answer: one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        unique case (idx)
          {2'h0, pcs_pkg::REG_CTRL_IDX}: wb_dat_o <= {16'h0000, ctrl_rd};
          {2'h0, pcs_pkg::REG_STAT_IDX}: wb_dat_o <= {16'h0000, stat_rd};
          {2'h0, pcs_pkg::REG_IDHI_IDX}: wb_dat_o <= {16'h0000, pcs_pkg::ID_HIGH_VALUE};
          pcs_pkg::REG_IRQ_STAT: wb_dat_o <= {28'h0000000, irq_stat_ff};
          pcs_pkg::REG_IRQ_MASK: wb_dat_o <= {28'h0000000, irq_mask_ff};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // pcs_regs

/* verification/pcs_regs_assertions.sv */
// assertions on the port register bank pins
`timescale 1ns/1ps
module pcs_regs_assertions (
  // bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // port side
  input wire logic renegotiate_trigger_o,
  input wire logic port_reset_o,
  input wire logic low_power_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd;
  logic wr;
  assign rd = wb_ack_o && !wb_we_i;
  assign wr = wb_ack_o && wb_we_i && wb_adr_i == 6'h00 && wb_sel_i[1];
  sequence s_srst;
    port_reset_o [*4] ##1 !port_reset_o;
  endsequence
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ctrl_ro;
    rd && wb_adr_i == 6'h00 |-> (wb_dat_o & 32'hFFFF_04FF) == 32'h0;
  endproperty
  a_ctrl_ro: assert property (p_ctrl_ro) else $error("ctrl zero bits");
  property p_stat_fixed;
    rd && wb_adr_i == 6'h04 |-> (wb_dat_o & 32'hFFFF_FFC9) == 32'h0000_7849;
  endproperty
  a_stat_fixed: assert property (p_stat_fixed) else $error("stat fixed");
  property p_id;
    rd && wb_adr_i == 6'h08 |-> wb_dat_o == {16'h0, pcs_pkg::ID_HIGH_VALUE};
  endproperty
  a_id: assert property (p_id) else $error("id word");
  property p_srst;
    $rose(port_reset_o) |-> s_srst;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset length");
  property p_reneg;
    $rose(port_reset_o) |-> ##[0:6] renegotiate_trigger_o;
  endproperty
  a_reneg: assert property (p_reneg) else $error("no restart");
  property p_wake;
    $fell(low_power_select_o) |-> ##[0:2] port_reset_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake no reset");
  property p_pwdn;
    wr |-> low_power_select_o == wb_dat_i[11];
  endproperty
  a_pwdn: assert property (p_pwdn) else $error("power down bit");
  property p_restart;
    wr && wb_dat_i[9] |-> ##[0:1] renegotiate_trigger_o;
  endproperty
  a_restart: assert property (p_restart) else $error("restart bit");
endmodule // pcs_regs_assertions
bind pcs_regs pcs_regs_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .renegotiate_trigger_o(renegotiate_trigger_o), .port_reset_o(port_reset_o),
  .low_power_select_o(low_power_select_o));

/* verification/pcs_phy_model.sv */
// far-end negotiation and link model
`timescale 1ns/1ps
module pcs_phy_model #(parameter int NEG_CYCLES = 6) (
  // clock
  input wire logic clk_i,
  // from the port
  input wire logic restart_i,
  input wire logic drop_i,
  input wire logic cable_i,
  // to the port
  output logic done_o,
  output logic link_o
);
  logic [3:0] cnt_ff;
  // restart abandons a negotiation in flight
  always_ff @(posedge clk_i) begin
    if (restart_i || drop_i || !cable_i) begin
      cnt_ff <= 4'(NEG_CYCLES);
      done_o <= 1'b0;
      link_o <= 1'b0;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end else begin
      done_o <= 1'b1;
      link_o <= 1'b1;
    end
  end
endmodule // pcs_phy_model

/* verification/pcs_regs_bench.sv */
// testbench for the port register bank
`timescale 1ns/1ps
module pcs_regs_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] rdat;
  logic [2:0] strap = 3'h5;
  logic fault = 1'b0;
  logic jab = 1'b0;
  logic cable = 1'b0;
  logic done;
  logic link;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, reneg, port_rst, pwdn, spd, anen, dup, drop, irq_o;
  int errors = 0;
  int n_compared = 0;
  always #5 clk_i = ~clk_i;
  pcs_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .negotiation_strap_pins_i(strap), .far_end_fault_i(fault),
    .jabber_i(jab), .link_up_i(link), .negotiation_complete_i(done),
    .renegotiate_trigger_o(reneg), .port_reset_o(port_rst), .low_power_select_o(pwdn),
    .speed_fast_o(spd), .negotiation_enable_o(anen), .full_duplex_o(dup),
    .link_drop_o(drop), .irq_o(irq_o));
  pcs_phy_model i_phy (.clk_i(clk_i), .restart_i(reneg), .drop_i(drop),
    .cable_i(cable), .done_o(done), .link_o(link));
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // entered just after a rising edge; request held until ack seen at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
    rdat = wb_dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    idle(4);
    rst_i <= 1'b0;
    cable <= 1'b1;
    idle(25);
    rd(6'h00, 32'h0000_2100);
    chk({29'h0, spd, anen, dup}, 32'h5);
    bus(1'b0, 6'h04, 32'h0);
    rd(6'h04, 32'h0000_786D);
    bus(1'b1, 6'h08, 32'hFFFF);
    rd(6'h08, {16'h0, pcs_pkg::ID_HIGH_VALUE});
    rd(6'h3C, 32'h0);
    bus(1'b1, 6'h00, 32'h3300);
    rd(6'h00, 32'h0000_3100);
    chk({29'h0, spd, anen, dup}, 32'h5);
    bus(1'b1, 6'h00, 32'hB100);
    rd(6'h00, 32'h0000_B100);
    idle(4);
    chk({29'h0, spd, anen, dup}, 32'h7);
    bus(1'b1, 6'h00, 32'h0800);
    chk({29'h0, spd, anen, dup}, 32'h7);
    bus(1'b1, 6'h00, 32'h0000);
    idle(30);
    chk({29'h0, spd, anen, dup}, 32'h0);
    bus(1'b0, 6'h30, 32'h0);
    bus(1'b0, 6'h04, 32'h0);
    rd(6'h04, 32'h0000_786D);
    fault <= 1'b1;
    jab <= 1'b1;
    cable <= 1'b0;
    idle(3);
    fault <= 1'b0;
    jab <= 1'b0;
    cable <= 1'b1;
    idle(25);
    chk({31'h0, irq_o}, 32'h0);
    bus(1'b1, 6'h34, 32'hF);
    idle(1);
    chk({31'h0, irq_o}, 32'h1);
    rd(6'h04, 32'h0000_787B);
    rd(6'h04, 32'h0000_786D);
    rd(6'h30, 32'hF);
    chk({31'h0, irq_o}, 32'h0);
    end_of_test();
  end
endmodule // pcs_regs_bench
